// [core/bpf_pkg.sv]
package bpf_pkg;
  // Address and table geometry
  localparam int ADDR_W      = 32;
  localparam int BTT_IDX_W   = 6;
  localparam int BTT_DEPTH   = 64;
  localparam int RAS_DEPTH   = 16;
  localparam int RAS_PTR_W   = 4;
  localparam int CHUNK_BYTES = 32;
  localparam int CHUNK_SH    = 5;
  localparam int TRACE_UOPS  = 12288;
  localparam int TRACE_IDX_W = 14;
  localparam int UOP_W       = 16;
  localparam int DLV_MAX     = 3;
  localparam int RET_MAX     = 3;
  localparam int RET_TAG_W   = 8;
  localparam int INSN_W      = 8;
  localparam logic [ADDR_W-1:0] RESET_PC = 32'h0000_0000;
  localparam logic [1:0] CTR_WEAK_T = 2'h2;

  // Control-transfer kinds seen at fetch/decode
  typedef enum logic [2:0] {
    BPF_K_NONE  = 3'h0,
    BPF_K_COND  = 3'h1,
    BPF_K_CALL  = 3'h2,
    BPF_K_RET   = 3'h3,
    BPF_K_IND   = 3'h4,
    BPF_K_FAR   = 3'h5
  } bpf_kind_t;

  // Decoder sequencing (Gray along usual path)
  typedef enum logic [1:0] {
    BPF_DEC_SIMPLE = 2'h0,
    BPF_DEC_ROM    = 2'h1,
    BPF_DEC_FLUSH  = 2'h3
  } bpf_dec_t;
endpackage : bpf_pkg

// [core/bpf_front_retire.sv]
// Operation
// RULE1: Predict every near transfer: conditional, call, return, indirect. An indirect with no valid entry falls through unpredicted here.
// RULE2: Never predict far calls, interrupt returns or software interrupts.
// RULE3: Table lookup of direction and target indexed by linear address.
// RULE4: With table history, predict before the branch is decoded.
// RULE5: No valid entry: backward conditional branch predicted taken.
// RULE6: No valid entry: forward branch predicted not taken.
// RULE7: Returns always taken, target from return-address stack.
// RULE8: Return-address stack holds 16 entries.
// RULE9: Retired branch writes resolved target and history into table.
// RULE10: Fetch follows predicted path in 32-byte chunks from target.
// RULE11: Single decoder handles at most one instruction per clock.
// RULE12: Complex instructions expand through a microcode ROM sequence.
// RULE13: Trace store holds 12K uops, delivers at most three per cycle.
// RULE14: Traces continue across predicted-taken branches.
// RULE15: Correct prediction adds no delay cycles.
// RULE16: Commit strictly in program order.
// RULE17: At most three uops retire per cycle.
// RULE18: Exceptions raised only at retirement, ordered by reorder queue.
// RULE19: Mispredict flushes younger work and redirects fetch.
`timescale 1ns/1ps
`default_nettype none
module bpf_front_retire
  import bpf_pkg::*;
(
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              SRST,
  // Fetch request to memory
  output logic [ADDR_W-1:0]      FETCH_ADDR,
  output logic                   FETCH_VALID,
  input  wire logic              FETCH_READY,
  // Pre-decoded instruction at fetch address
  input  wire logic              INSN_VALID,
  input  wire bpf_kind_t         INSN_KIND,
  input  wire logic [ADDR_W-1:0] INSN_TARGET,
  input  wire logic [3:0]        INSN_LEN,
  input  wire logic              INSN_COMPLEX,
  input  wire logic [INSN_W-1:0] INSN_OPC,
  // Microcode ROM sequence
  output logic                   UROM_REQ,
  output logic [INSN_W-1:0]      UROM_OPC,
  input  wire logic              UROM_DONE,
  input  wire logic [UOP_W-1:0]  UROM_UOP,
  // Uop delivery to core
  output logic [DLV_MAX-1:0]     UOP_VALID,
  output logic [UOP_W*DLV_MAX-1:0] UOP_DATA,
  output logic                   PRED_TAKEN,
  output logic [ADDR_W-1:0]      PRED_TARGET,
  // Completion reorder queue head, oldest in slot 0
  input  wire logic [RET_MAX-1:0] CRQ_DONE,
  input  wire logic [RET_MAX-1:0] CRQ_EXC,
  input  wire logic [RET_MAX-1:0] CRQ_BR,
  input  wire logic [RET_MAX-1:0] CRQ_MISP,
  input  wire logic [ADDR_W*RET_MAX-1:0] CRQ_PC,
  input  wire logic [ADDR_W*RET_MAX-1:0] CRQ_TGT,
  input  wire logic [RET_MAX-1:0] CRQ_TAKEN,
  // Retirement results
  output logic [RET_MAX-1:0]     COMMIT,
  output logic                   EXC_RAISE,
  output logic [ADDR_W-1:0]      EXC_PC,
  output logic                   FLUSH
);

  function automatic logic [BTT_IDX_W-1:0] btt_idx(input logic [ADDR_W-1:0] a);
    return a[BTT_IDX_W-1:0];
  endfunction

  // Ring is not a power of two, so pointers wrap at its real size
  function automatic logic [TRACE_IDX_W-1:0] tr_add(input logic [TRACE_IDX_W-1:0] p,
                                                    input logic [TRACE_IDX_W-1:0] n);
    logic [TRACE_IDX_W:0] s;
    s = {1'b0, p} + {1'b0, n};
    return (s >= (TRACE_IDX_W+1)'(TRACE_UOPS)) ?
           TRACE_IDX_W'(s - (TRACE_IDX_W+1)'(TRACE_UOPS)) : TRACE_IDX_W'(s);
  endfunction

  // Uops waiting between read and write pointers
  function automatic logic [TRACE_IDX_W-1:0] tr_fill(input logic [TRACE_IDX_W-1:0] wr,
                                                     input logic [TRACE_IDX_W-1:0] rd);
    return (wr >= rd) ? TRACE_IDX_W'(wr - rd)
                      : TRACE_IDX_W'(wr + TRACE_IDX_W'(TRACE_UOPS) - rd);
  endfunction

  // Branch target table storage
  logic [ADDR_W-1:0] btt_tgt [BTT_DEPTH];
  logic [1:0]        btt_ctr [BTT_DEPTH];
  logic [BTT_DEPTH-1:0] btt_vld;
  // Return-address stack
  logic [ADDR_W-1:0] ras [RAS_DEPTH];
  logic [RAS_PTR_W-1:0] ras_sp, next_ras_sp;
  // Trace store: a 12K-uop array, written by the decoder
  logic [UOP_W-1:0] trace_mem [TRACE_UOPS];
  logic [TRACE_IDX_W-1:0] tr_wr, next_tr_wr, tr_rd, next_tr_rd;
  logic [ADDR_W-1:0] pc, next_pc;
  bpf_dec_t dec_st, next_dec_st;
  logic [INSN_W-1:0] rom_opc, next_rom_opc;

  // Prediction: table hit first, static fallback, return stack
  logic [BTT_IDX_W-1:0] li;
  logic hit, taken;
  logic [ADDR_W-1:0] tgt, seq_pc, ret_addr;
  logic mis_any;
  logic [ADDR_W-1:0] mis_tgt;
  logic [RET_MAX-1:0] ret_ok;
  always_comb begin
    li = btt_idx(pc);
    // RULE3 linear-address lookup
    hit = btt_vld[li];
    seq_pc = pc + {28'h0, INSN_LEN};
    ret_addr = ras[RAS_PTR_W'(ras_sp - 4'h1)];
    taken = 1'b0;
    tgt = seq_pc;
    unique case (INSN_KIND)
      // RULE7 return from stack
      BPF_K_RET: begin
        taken = 1'b1;
        tgt = ret_addr;
      end
      BPF_K_CALL, BPF_K_IND: begin
        // RULE1 calls always predicted; indirect predicted only on a table hit
        taken = 1'b1;
        tgt = (hit || INSN_KIND == BPF_K_CALL) ? (hit ? btt_tgt[li] : INSN_TARGET) : seq_pc;
        taken = hit || INSN_KIND == BPF_K_CALL;
      end
      BPF_K_COND: begin
        if (hit) begin
          // RULE4 history predicts pre-decode
          taken = btt_ctr[li][1];
          tgt = taken ? btt_tgt[li] : seq_pc;
        end else begin
          // RULE5 backward taken
          // RULE6 forward not taken
          taken = INSN_TARGET < pc;
          tgt = taken ? INSN_TARGET : seq_pc;
        end
      end
      // RULE2 far transfers unpredicted
      BPF_K_FAR, BPF_K_NONE: begin
        taken = 1'b0;
        tgt = seq_pc;
      end
      default: begin
        taken = 1'b0;
        tgt = seq_pc;
      end
    endcase
  end

  // Retirement: in-order prefix of done uops, stop at exception
  always_comb begin
    ret_ok = '0;
    mis_any = 1'b0;
    mis_tgt = '0;
    // RULE16 program-order prefix
    // RULE17 three slots max
    for (int i = 0; i < RET_MAX; i++) begin
      if (CRQ_DONE[i] && (i == 0 || ret_ok[i-1]) && !mis_any
          && !(i > 0 && CRQ_EXC[i-1])) begin
        ret_ok[i] = 1'b1;
        if (CRQ_BR[i] && CRQ_MISP[i] && !CRQ_EXC[i]) begin
          mis_any = 1'b1;
          mis_tgt = CRQ_TGT[i*ADDR_W +: ADDR_W];
        end
      end
    end
  end

  // Next-state for fetch, stack, decoder and trace pointers
  logic step;
  always_comb begin
    step = FETCH_READY && INSN_VALID && dec_st == BPF_DEC_SIMPLE;
    next_pc = pc;
    next_ras_sp = ras_sp;
    next_dec_st = dec_st;
    next_rom_opc = rom_opc;
    next_tr_wr = tr_wr;
    next_tr_rd = tr_rd;
    // RULE10 predicted path fetch
    // RULE15 redirect same cycle, no bubble
    if (step) begin
      next_pc = taken ? tgt : seq_pc;
      if (INSN_KIND == BPF_K_CALL) next_ras_sp = RAS_PTR_W'(ras_sp + 4'h1);
      if (INSN_KIND == BPF_K_RET) next_ras_sp = RAS_PTR_W'(ras_sp - 4'h1);
      // RULE12 complex goes to ROM
      if (INSN_COMPLEX) begin
        next_dec_st = BPF_DEC_ROM;
        next_rom_opc = INSN_OPC;
      end
      // RULE14 trace continues through taken branch
      next_tr_wr = tr_add(tr_wr, 14'h1);
    end
    // ROM uop takes its own trace slot
    if (dec_st == BPF_DEC_ROM && UROM_DONE) begin
      next_dec_st = BPF_DEC_SIMPLE;
      next_tr_wr = tr_add(tr_wr, 14'h1);
    end
    if (dec_st == BPF_DEC_FLUSH) next_dec_st = BPF_DEC_SIMPLE;
    // RULE13 up to three from trace store
    if (tr_rd != tr_wr) begin
      if (tr_fill(tr_wr, tr_rd) >= 14'h3) next_tr_rd = tr_add(tr_rd, 14'h3);
      else next_tr_rd = tr_wr;
    end
    // RULE19 flush and redirect
    if (mis_any) begin
      next_pc = mis_tgt;
      next_dec_st = BPF_DEC_FLUSH;
      next_tr_rd = next_tr_wr;
    end
  end

  // Registered state and tables
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pc <= RESET_PC;
      ras_sp <= '0;
      dec_st <= BPF_DEC_SIMPLE;
      rom_opc <= '0;
      tr_wr <= '0;
      tr_rd <= '0;
      btt_vld <= '0;
      COMMIT <= '0;
      EXC_RAISE <= 1'b0;
      EXC_PC <= '0;
      FLUSH <= 1'b0;
      UOP_VALID <= '0;
      UOP_DATA <= '0;
      PRED_TAKEN <= 1'b0;
      PRED_TARGET <= '0;
    end else begin
      pc <= next_pc;
      ras_sp <= next_ras_sp;
      dec_st <= next_dec_st;
      rom_opc <= next_rom_opc;
      tr_wr <= next_tr_wr;
      tr_rd <= next_tr_rd;
      // RULE8 sixteen-entry stack wraps
      if (step && INSN_KIND == BPF_K_CALL) ras[ras_sp] <= seq_pc;
      // RULE11 one instruction per clock
      if (step) trace_mem[tr_wr] <= {INSN_OPC, 5'h0, INSN_KIND};
      else if (dec_st == BPF_DEC_ROM && UROM_DONE) trace_mem[tr_wr] <= UROM_UOP;
      // RULE9 retire updates table
      for (int i = 0; i < RET_MAX; i++) begin
        if (ret_ok[i] && CRQ_BR[i] && !CRQ_EXC[i]) begin
          btt_vld[btt_idx(CRQ_PC[i*ADDR_W +: ADDR_W])] <= 1'b1;
          btt_tgt[btt_idx(CRQ_PC[i*ADDR_W +: ADDR_W])] <= CRQ_TGT[i*ADDR_W +: ADDR_W];
          btt_ctr[btt_idx(CRQ_PC[i*ADDR_W +: ADDR_W])] <= CRQ_TAKEN[i] ? 2'h3 : 2'h0;
        end
      end
      COMMIT <= ret_ok;
      // RULE18 exception only at retirement
      EXC_RAISE <= 1'b0;
      for (int i = RET_MAX - 1; i >= 0; i--) begin
        if (ret_ok[i] && CRQ_EXC[i]) begin
          EXC_RAISE <= 1'b1;
          EXC_PC <= CRQ_PC[i*ADDR_W +: ADDR_W];
        end
      end
      FLUSH <= mis_any;
      for (int k = 0; k < DLV_MAX; k++) begin
        UOP_VALID[k] <= !mis_any && (tr_fill(tr_wr, tr_rd) > TRACE_IDX_W'(k));
        UOP_DATA[k*UOP_W +: UOP_W] <= trace_mem[tr_add(tr_rd, TRACE_IDX_W'(k))];
      end
      PRED_TAKEN <= step && taken;
      PRED_TARGET <= tgt;
    end
  end

  // Handshake outputs
  assign FETCH_ADDR = {pc[ADDR_W-1:CHUNK_SH], 5'h0};
  assign FETCH_VALID = dec_st == BPF_DEC_SIMPLE;
  assign UROM_REQ = dec_st == BPF_DEC_ROM;
  assign UROM_OPC = rom_opc;

  // Checks
  retire_bound_a: assert property (@(posedge CLK) disable iff (SRST) // RULE17
    $countones(COMMIT) <= RET_MAX) else $error("too many retired");
  retire_order_a: assert property (@(posedge CLK) disable iff (SRST) // RULE16
    COMMIT[1] |-> COMMIT[0]) else $error("out of order commit");
  far_nopred_a: assert property (@(posedge CLK) disable iff (SRST) // RULE2
    step && INSN_KIND == BPF_K_FAR |=> !PRED_TAKEN) else $error("far predicted");
  ret_taken_a: assert property (@(posedge CLK) disable iff (SRST) // RULE7
    step && INSN_KIND == BPF_K_RET |=> PRED_TAKEN) else $error("return not taken");
  static_fwd_a: assert property (@(posedge CLK) disable iff (SRST) // RULE6
    step && INSN_KIND == BPF_K_COND && !hit && INSN_TARGET > pc |=> !PRED_TAKEN)
    else $error("forward taken");
  static_back_a: assert property (@(posedge CLK) disable iff (SRST) // RULE5
    step && INSN_KIND == BPF_K_COND && !hit && INSN_TARGET < pc |=> PRED_TAKEN)
    else $error("backward not taken");
  misp_flush_a: assert property (@(posedge CLK) disable iff (SRST) // RULE19
    mis_any |=> FLUSH && pc == $past(mis_tgt)) else $error("no redirect");
  chunk_align_a: assert property (@(posedge CLK) disable iff (SRST) // RULE10
    FETCH_ADDR[CHUNK_SH-1:0] == 5'h0) else $error("fetch unaligned");
endmodule // bpf_front_retire
`default_nettype wire

// [test/bpf_far_model.sv]
`timescale 1ns/1ps
`default_nettype none
module bpf_far_model
  import bpf_pkg::*;
#(
  parameter int ROM_LAT = 3
)(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Memory side
  input  wire logic        stall,
  output logic             fetch_ready,
  // Microcode ROM side
  input  wire logic        urom_req,
  output logic             urom_done,
  output logic [UOP_W-1:0] urom_uop
);
  logic [3:0] cnt;

  // A stalled memory simply refuses fetches
  assign fetch_ready = !stall;

  // ROM answers after a fixed wait; done is a single-cycle pulse
  always_ff @(posedge clk) begin
    if (srst || !urom_req || urom_done) begin
      cnt       <= 4'h0;
      urom_done <= 1'b0;
    end else begin
      cnt       <= cnt + 4'h1;
      urom_done <= (cnt == ROM_LAT[3:0]);
    end
  end

  // Outside the pulse the uop shows the wait count, so stale data never matches
  assign urom_uop = urom_done ? 16'hC0DE : {12'h0, cnt};
endmodule // bpf_far_model
`default_nettype wire

// [test/branch_predict_fetch_retire_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module branch_predict_fetch_retire_bench
  import bpf_pkg::*;
;
  typedef struct packed {
    bpf_kind_t   k;
    logic [31:0] t;
    logic [3:0]  l;
    logic        tk;
    logic [31:0] pt;
  } bpf_row_t;

  logic        clk = 1'b0;
  logic        srst, fetch_ready, insn_valid, insn_complex, urom_req, urom_done;
  logic        fetch_valid, pred_taken, exc_raise, flush;
  bpf_kind_t   insn_kind;
  logic [31:0] insn_target, fetch_addr, pred_target, exc_pc;
  logic [3:0]  insn_len;
  logic [7:0]  insn_opc, urom_opc;
  logic [15:0] urom_uop;
  logic [2:0]  crq_done, crq_exc, crq_br, crq_misp, crq_taken, uop_valid, commit;
  logic [95:0] crq_pc, crq_tgt;
  logic [47:0] uop_data;
  int          mismatches, check_count, cycles, n;
  // Steps follow one another, so the pc of each row is known
  bpf_row_t rows [7] = '{
    '{BPF_K_COND, 32'h100, 4'h4, 1'b0, 32'h0},  '{BPF_K_CALL, 32'h200, 4'h5, 1'b1, 32'h200},
    '{BPF_K_COND, 32'h40, 4'h2, 1'b1, 32'h40},  '{BPF_K_FAR, 32'h300, 4'h7, 1'b0, 32'h0},
    '{BPF_K_IND, 32'h500, 4'h2, 1'b0, 32'h0},   '{BPF_K_RET, 32'h999, 4'h1, 1'b1, 32'h9},
    '{BPF_K_NONE, 32'h0, 4'h1, 1'b0, 32'h0}};

  // Clock, 40 ns period
  always #20 clk = !clk;

  bpf_front_retire bpf_front_retire_inst (
    .CLK(clk), .SRST(srst), .FETCH_ADDR(fetch_addr), .FETCH_VALID(fetch_valid),
    .FETCH_READY(fetch_ready), .INSN_VALID(insn_valid), .INSN_KIND(insn_kind),
    .INSN_TARGET(insn_target), .INSN_LEN(insn_len), .INSN_COMPLEX(insn_complex),
    .INSN_OPC(insn_opc), .UROM_REQ(urom_req), .UROM_OPC(urom_opc), .UROM_DONE(urom_done),
    .UROM_UOP(urom_uop), .UOP_VALID(uop_valid), .UOP_DATA(uop_data),
    .PRED_TAKEN(pred_taken), .PRED_TARGET(pred_target), .CRQ_DONE(crq_done),
    .CRQ_EXC(crq_exc), .CRQ_BR(crq_br), .CRQ_MISP(crq_misp), .CRQ_PC(crq_pc),
    .CRQ_TGT(crq_tgt), .CRQ_TAKEN(crq_taken), .COMMIT(commit), .EXC_RAISE(exc_raise),
    .EXC_PC(exc_pc), .FLUSH(flush));

  bpf_far_model bpf_far_model_inst (
    .clk(clk), .srst(srst), .stall(1'b0), .fetch_ready(fetch_ready),
    .urom_req(urom_req), .urom_done(urom_done), .urom_uop(urom_uop));

  task automatic chk_bit(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Present a retire group for one cycle, then look at the registered answer
  task automatic retire(input logic [2:0] d, e, b, m, tk, input logic [95:0] p, t);
    @(posedge clk);
    {crq_done, crq_exc, crq_br, crq_misp, crq_taken} <= {d, e, b, m, tk};
    {crq_pc, crq_tgt} <= {p, t};
    @(posedge clk);
    {crq_done, crq_exc, crq_br, crq_misp, crq_taken} <= 15'h0;
    #1;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Cuts a hang short; the whole run needs a few dozen cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    {srst, insn_valid, insn_complex, insn_opc, insn_target, insn_len} = {1'b1, 46'h0};
    insn_kind = BPF_K_NONE;
    {crq_done, crq_exc, crq_br, crq_misp, crq_taken, crq_pc, crq_tgt} = 207'h0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    // Back-to-back steps; each prediction is checked as the next row is sent
    for (int i = 0; i <= 7; i++) begin
      @(posedge clk);
      insn_valid <= (i < 7);
      if (i < 7) {insn_kind, insn_target, insn_len} <= {rows[i].k, rows[i].t, rows[i].l};
      if (i > 0) begin
        #1;
        chk_bit("pred_taken", rows[i-1].tk, pred_taken);
        if (rows[i-1].tk) begin
          chk_word("pred_target", rows[i-1].pt, pred_target);
          chk_word("fetch_addr", rows[i-1].pt & ~32'h1F, fetch_addr);
        end
        if (i == 2) begin
          chk_word("uop_valid", 32'h1, {29'h0, uop_valid});
          chk_word("uop_data", 32'h1, {16'h0, uop_data[15:0]});
        end
      end
    end
    $display("test prediction rows done");
    retire(3'b101, 3'h0, 3'h0, 3'h0, 3'h0, 96'h0, 96'h0);
    chk_word("commit", 32'h1, {29'h0, commit});
    retire(3'b111, 3'h0, 3'h0, 3'h0, 3'h0, 96'h0, 96'h0);
    chk_word("commit", 32'h7, {29'h0, commit});
    retire(3'b111, 3'b010, 3'h0, 3'h0, 3'h0, {32'h0, 32'h1234, 32'h0}, 96'h0);
    chk_word("commit", 32'h3, {29'h0, commit});
    chk_bit("exc_raise", 1'b1, exc_raise);
    chk_word("exc_pc", 32'h1234, exc_pc);
    $display("test retire order done");
    // Older taken branch trains the table; younger mispredict redirects to it
    retire(3'b011, 3'h0, 3'b011, 3'b010, 3'b001, {32'h0, 32'h10, 32'h2C0},
           {32'h0, 32'h2C0, 32'h80});
    chk_word("commit", 32'h3, {29'h0, commit});
    chk_bit("flush", 1'b1, flush);
    chk_bit("fetch_valid", 1'b0, fetch_valid);
    chk_word("fetch_addr", 32'h2C0, fetch_addr);
    @(posedge clk);
    {insn_valid, insn_kind, insn_target, insn_len} <= {1'b1, BPF_K_COND, 32'h300, 4'h2};
    @(posedge clk);
    insn_valid <= 1'b0;
    #1;
    chk_bit("pred_taken", 1'b1, pred_taken);
    chk_word("pred_target", 32'h80, pred_target);
    $display("test table update done");
    @(posedge clk);
    {insn_valid, insn_kind, insn_complex, insn_opc} <= {1'b1, BPF_K_NONE, 1'b1, 8'h5A};
    @(posedge clk);
    {insn_valid, insn_complex} <= 2'b00;
    #1;
    chk_bit("urom_req", 1'b1, urom_req);
    chk_word("urom_opc", 32'h5A, {24'h0, urom_opc});
    chk_bit("fetch_valid", 1'b0, fetch_valid);
    for (n = 0; n < 20 && fetch_valid !== 1'b1; n++) @(posedge clk);
    #1;
    chk_bit("fetch_valid", 1'b1, fetch_valid);
    $display("test microcode done");
    @(posedge clk);
    {srst, crq_done} <= {1'b1, 3'b111};
    @(posedge clk);
    {srst, crq_done} <= 4'h0;
    #1;
    chk_word("commit", 32'h0, {29'h0, commit});
    chk_word("fetch_addr", 32'h0, fetch_addr);
    chk_bit("fetch_valid", 1'b1, fetch_valid);
    $display("test reset done");
    results();
  end
endmodule // branch_predict_fetch_retire_bench
`default_nettype wire
